// file: shc_cfg.svh
/*
 * Constants of the standby halt controller: modes, timing, register map.
 * Assumes one 40 MHz clock that is also the oscillator input.
 */
`ifndef SHC_CFG_SVH
`define SHC_CFG_SVH
`define SHC_MODE_RUN   2'h0
`define SHC_MODE_STOP  2'h1
`define SHC_MODE_OIDLE 2'h2
`define SHC_MODE_PIDLE 2'h3
`define SHC_NMI_LEVEL  3'h7
`define SHC_ENTER_CYC  2'h3
`define SHC_WARM_RST   16'h0100
`define SHC_RST_HOLD_MS  3
`define SHC_MCLK_KHZ     40000
`define SHC_RST_HOLD_CYC (`SHC_RST_HOLD_MS * `SHC_MCLK_KHZ)
`define SHC_OFS_CTRL   5'h00
`define SHC_OFS_WARM   5'h04
`define SHC_OFS_STAT   5'h08
`define SHC_OFS_EVT    5'h0c
`define SHC_OFS_MASK   5'h10
`define SHC_EV_ENTER   0
`define SHC_EV_SERVE   1
`define SHC_EV_RESUME  2
`define SHC_EV_HELD    3
`define SHC_EV_W       4
`endif

// file: shc_pkg.sv
/*
 * Types shared by the standby halt controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package shc_pkg;
	typedef enum logic [3:0] {
		ST_ACT   = 4'b0001,
		ST_ENTER = 4'b0010,
		ST_HALT  = 4'b0100,
		ST_WARM  = 4'b1000
	} shc_state_t;

	typedef struct packed {
		logic       nmi;
		logic       ext;
		logic [2:0] ext_lvl;
		logic       wdt;
		logic [2:0] wdt_lvl;
		logic       adc;
		logic [2:0] adc_lvl;
		logic       per;
		logic [2:0] per_lvl;
	} shc_wake_req_t;

	typedef struct packed {
		logic cpu;
		logic periph;
		logic subset;
		logic osc;
	} shc_clk_gate_t;
endpackage
`default_nettype wire

// file: shc_standby_ctrl.sv
/*
 * Standby halt controller: enters the selected low-power mode on a halt
 * instruction, gates clocks, decides wake-up and times oscillator warm-up.
 * Assumes the cpu gives one-cycle instruction pulses and the interrupt
 * controller gives one-cycle request pulses with levels, all on mclk.
 */
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
`include "shc_cfg.svh"

module shc_standby_ctrl #(
	parameter int WARM_W = 16
) (
	input  wire logic                  mclk,              // 40 MHz clock
	input  wire logic                  resetn,            // sync reset
	input  wire logic [4:0]            avs_address,       // byte address
	input  wire logic                  avs_read,          // read strobe
	input  wire logic                  avs_write,         // write strobe
	input  wire logic [31:0]           avs_writedata,     // write data
	output logic      [31:0]           avs_readdata,      // read data
	output logic                       avs_waitrequest,   // stall
	input  wire logic                  halt_exec,         // halt pulse
	input  wire logic [2:0]            irq_mask_level,    // cpu mask
	input  wire shc_pkg::shc_wake_req_t wake_req,         // requests
	input  wire logic                  held_ack,          // held taken
	input  wire logic                  enable_irq_instr,  // ei pulse
	input  wire logic                  disable_irq_instr, // di pulse
	input  wire logic                  flag_clear_instr,  // clear pulse
	output shc_pkg::shc_clk_gate_t     clk_gate,          // enables
	output logic                       serve_pulse,       // wake, serve
	output logic                       resume_pulse,      // wake, resume
	output logic                       held_nmi,          // nmi pending
	output logic                       held_ext,          // ext pending
	output logic                       ext_flag_keep,     // ext flag kept
	output logic                       irq_enabled,       // ie state
	output logic                       flag_clear_apply,  // clear lands
	output logic                       irq                // interrupt
);

	function automatic shc_pkg::shc_clk_gate_t gates(
		input shc_pkg::shc_state_t st,
		input logic [1:0]          md
	);
		shc_pkg::shc_clk_gate_t g;
		g = '0;
		case (st)
		shc_pkg::ST_ACT: begin
			g = '1;
		end
		shc_pkg::ST_WARM: begin
			g.osc = 1'b1;
		end
		shc_pkg::ST_ENTER, shc_pkg::ST_HALT: begin
			case (md)
			`SHC_MODE_RUN: begin
				g.periph = 1'b1;
				g.subset = 1'b1;
				g.osc    = 1'b1;
			end
			`SHC_MODE_PIDLE: begin
				g.subset = 1'b1;
				g.osc    = 1'b1;
			end
			`SHC_MODE_OIDLE: begin
				g.osc = 1'b1;
			end
			default: begin
				g.osc = 1'b0;
			end
			endcase
		end
		default: begin
			g = '1;
		end
		endcase
		return g;
	endfunction

	function automatic logic above(
		input logic [2:0] lvl,
		input logic [2:0] mask
	);
		return lvl > mask;
	endfunction

	shc_pkg::shc_state_t    state_reg;
	shc_pkg::shc_state_t    state_next;
	shc_pkg::shc_clk_gate_t gate_reg;
	logic [1:0]             mode_sel_reg;
	logic [1:0]             mode_reg;
	logic [1:0]             mode_eff;
	logic [WARM_W-1:0]      warm_reg;
	logic [WARM_W-1:0]      warm_cnt_reg;
	logic [1:0]             enter_cnt_reg;
	logic                   svc;
	logic                   resume_only;
	logic                   wake;
	logic                   svc_keep_reg;
	logic                   serve_reg;
	logic                   resume_reg;
	logic                   held_nmi_reg;
	logic                   held_ext_reg;
	logic                   ext_keep_reg;
	logic                   irq_en_reg;
	logic                   clr_d1_reg;
	logic                   clr_apply_reg;
	logic                   ack_reg;
	logic                   wr_go;
	logic                   rd_go;
	logic [31:0]            rd_mux;
	logic [31:0]            rdata_reg;
	logic [`SHC_EV_W-1:0]   evt_reg;
	logic [`SHC_EV_W-1:0]   evt_set;
	logic [`SHC_EV_W-1:0]   mask_reg;
	logic                   to_act;
	logic                   halt_go;

	// wake decision; the non-maskable source skips the level compare,
	// so it is taken whatever the mask holds
	always_comb begin
		svc = wake_req.nmi;
		svc = svc | (wake_req.ext &&
			above(wake_req.ext_lvl, irq_mask_level));
		if (mode_reg == `SHC_MODE_RUN) begin
			svc = svc | (wake_req.wdt &&
				above(wake_req.wdt_lvl, irq_mask_level));
			svc = svc | (wake_req.adc &&
				above(wake_req.adc_lvl, irq_mask_level));
		end
		if (mode_reg == `SHC_MODE_RUN ||
		    mode_reg == `SHC_MODE_PIDLE) begin
			svc = svc | (wake_req.per &&
				above(wake_req.per_lvl, irq_mask_level));
		end
		resume_only = wake_req.ext && !svc;
	end

	// in oscillator idle the request path is pure logic, so it sees the
	// request without the stopped system clock; the move out is clocked
	assign wake    = (state_reg == shc_pkg::ST_HALT) &&
	                 (svc || resume_only);
	assign halt_go = (state_reg == shc_pkg::ST_ACT) && halt_exec;
	assign mode_eff = halt_go ? mode_sel_reg : mode_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		shc_pkg::ST_ACT: begin
			if (halt_exec) begin
				if (mode_sel_reg == `SHC_MODE_STOP ||
				    mode_sel_reg == `SHC_MODE_OIDLE) begin
					state_next = shc_pkg::ST_ENTER;
				end else begin
					state_next = shc_pkg::ST_HALT;
				end
			end
		end
		shc_pkg::ST_ENTER: begin
			if (enter_cnt_reg == `SHC_ENTER_CYC - 2'h1) begin
				state_next = shc_pkg::ST_HALT;
			end
		end
		shc_pkg::ST_HALT: begin
			if (wake) begin
				if (mode_reg == `SHC_MODE_STOP) begin
					state_next = shc_pkg::ST_WARM;
				end else begin
					state_next = shc_pkg::ST_ACT;
				end
			end
		end
		shc_pkg::ST_WARM: begin
			if (warm_cnt_reg >= warm_reg) begin
				state_next = shc_pkg::ST_ACT;
			end
		end
		default: begin
			state_next = shc_pkg::ST_ACT;
		end
		endcase
	end

	assign to_act = (state_next == shc_pkg::ST_ACT) &&
	                (state_reg == shc_pkg::ST_HALT ||
	                 state_reg == shc_pkg::ST_WARM);

	// reset drops any standby at once; ram is not held here, so it
	// keeps its contents while every setting below returns to default
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= shc_pkg::ST_ACT;
			gate_reg  <= '1;
		end else begin
			state_reg <= state_next;
			gate_reg  <= gates(state_next, mode_eff);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mode_reg <= `SHC_MODE_RUN;
		end else if (halt_go) begin
			mode_reg <= mode_sel_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn || state_reg != shc_pkg::ST_ENTER) begin
			enter_cnt_reg <= 2'h0;
		end else begin
			enter_cnt_reg <= enter_cnt_reg + 2'h1;
		end
	end

	// mclk is the oscillator input, so this counts restarted cycles
	always_ff @(posedge mclk) begin
		if (!resetn || state_reg != shc_pkg::ST_WARM) begin
			warm_cnt_reg <= '0;
		end else begin
			warm_cnt_reg <= warm_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			svc_keep_reg <= 1'b0;
			serve_reg    <= 1'b0;
			resume_reg   <= 1'b0;
		end else begin
			if (wake) begin
				svc_keep_reg <= svc;
			end
			if (state_reg == shc_pkg::ST_WARM) begin
				serve_reg  <= to_act && svc_keep_reg;
				resume_reg <= to_act && !svc_keep_reg;
			end else begin
				serve_reg  <= to_act && svc;
				resume_reg <= to_act && resume_only;
			end
		end
	end

	// requests in the entry window do not wake; nmi and ext ones stay pending
	// until held_ack, which the interrupt controller gives with the next serve
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			held_nmi_reg <= 1'b0;
			held_ext_reg <= 1'b0;
		end else begin
			held_nmi_reg <= (held_nmi_reg && !held_ack) ||
				(state_reg == shc_pkg::ST_ENTER &&
				 wake_req.nmi);
			held_ext_reg <= (held_ext_reg && !held_ack) ||
				(state_reg == shc_pkg::ST_ENTER &&
				 wake_req.ext);
		end
	end

	// a level ext line must stay high until service starts; the kept
	// flag only covers the below-mask resume straight from halt, not the one after full-stop warm-up
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ext_keep_reg <= 1'b0;
		end else begin
			ext_keep_reg <= (ext_keep_reg && !clr_apply_reg) ||
				(to_act && state_reg == shc_pkg::ST_HALT &&
				 resume_only);
		end
	end

	// clear lands two cycles on, enable one: an enable placed right
	// after a clear opens the gate before the flag drops
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_en_reg    <= 1'b0;
			clr_d1_reg    <= 1'b0;
			clr_apply_reg <= 1'b0;
		end else begin
			if (disable_irq_instr) begin
				irq_en_reg <= 1'b0;
			end else if (enable_irq_instr) begin
				irq_en_reg <= 1'b1;
			end
			clr_d1_reg    <= flag_clear_instr;
			clr_apply_reg <= clr_d1_reg;
		end
	end

	// bus: one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign wr_go = avs_write && ack_reg;
	assign rd_go = avs_read && ack_reg;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
		`SHC_OFS_CTRL: rd_mux[1:0] = mode_sel_reg;
		`SHC_OFS_WARM: rd_mux[WARM_W-1:0] = warm_reg;
		`SHC_OFS_STAT: rd_mux[9:0] = {irq_en_reg, ext_keep_reg,
			held_ext_reg, held_nmi_reg, mode_reg, state_reg};
		`SHC_OFS_EVT:  rd_mux[`SHC_EV_W-1:0] = evt_reg;
		`SHC_OFS_MASK: rd_mux[`SHC_EV_W-1:0] = mask_reg;
		default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read && !ack_reg) begin
			rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mode_sel_reg <= `SHC_MODE_RUN;
			warm_reg     <= WARM_W'(`SHC_WARM_RST);
			mask_reg     <= '0;
		end else if (wr_go) begin
			case (avs_address)
			`SHC_OFS_CTRL: mode_sel_reg <= avs_writedata[1:0];
			`SHC_OFS_WARM: warm_reg <= avs_writedata[WARM_W-1:0];
			`SHC_OFS_MASK: mask_reg <= avs_writedata[`SHC_EV_W-1:0];
			default:       mask_reg <= mask_reg;
			endcase
		end
	end

	// only bits that were captured for the read are cleared, so an
	// event landing during the access survives
	always_comb begin
		evt_set = '0;
		evt_set[`SHC_EV_ENTER]  = halt_go;
		evt_set[`SHC_EV_SERVE]  = serve_reg;
		evt_set[`SHC_EV_RESUME] = resume_reg;
		evt_set[`SHC_EV_HELD]   = state_reg == shc_pkg::ST_ENTER &&
			(wake_req.nmi || wake_req.ext);
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			evt_reg <= '0;
		end else if (rd_go && avs_address == `SHC_OFS_EVT) begin
			evt_reg <= (evt_reg & ~rdata_reg[`SHC_EV_W-1:0]) | evt_set;
		end else begin
			evt_reg <= evt_reg | evt_set;
		end
	end

	assign avs_readdata     = rdata_reg;
	assign clk_gate         = gate_reg;
	assign serve_pulse      = serve_reg;
	assign resume_pulse     = resume_reg;
	assign held_nmi         = held_nmi_reg;
	assign held_ext         = held_ext_reg;
	assign ext_flag_keep    = ext_keep_reg;
	assign irq_enabled      = irq_en_reg;
	assign flag_clear_apply = clr_apply_reg;
	assign irq              = |(evt_reg & mask_reg);

	halt_cpu_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT |-> !clk_gate.cpu)
		else $error("cpu clock running in halt");

	stop_osc_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && mode_reg == `SHC_MODE_STOP
		|-> clk_gate == '0)
		else $error("clock alive in full stop");

	oidle_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && mode_reg == `SHC_MODE_OIDLE
		|-> clk_gate.osc && !clk_gate.subset && !clk_gate.periph)
		else $error("bad gates in oscillator idle");

	pidle_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && mode_reg == `SHC_MODE_PIDLE
		|-> clk_gate.subset && clk_gate.osc && !clk_gate.periph)
		else $error("bad gates in peripheral idle");

	enter_len_a: assert property (@(posedge mclk) disable iff (!resetn)
		halt_go && mode_sel_reg == `SHC_MODE_OIDLE
		|=> (state_reg == shc_pkg::ST_ENTER)[*3]
		##1 state_reg == shc_pkg::ST_HALT)
		else $error("entry window not three cycles");

	nmi_wake_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && wake_req.nmi &&
		mode_reg != `SHC_MODE_STOP |=> serve_pulse && clk_gate.cpu)
		else $error("nmi did not wake and serve");

	stop_warm_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && mode_reg == `SHC_MODE_STOP &&
		wake_req.ext |=> state_reg == shc_pkg::ST_WARM && !serve_pulse)
		else $error("full stop skipped warm-up");

	warm_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_WARM && warm_cnt_reg < warm_reg
		|=> state_reg == shc_pkg::ST_WARM && !clk_gate.cpu)
		else $error("warm-up cut short");

	ext_resume_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && mode_reg == `SHC_MODE_RUN &&
		resume_only |=> resume_pulse && ext_flag_keep && !serve_pulse)
		else $error("ext below mask not resumed");

	mask_stay_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_HALT && !wake_req.nmi && !wake_req.ext
		&& mode_reg == `SHC_MODE_OIDLE
		|=> state_reg == shc_pkg::ST_HALT)
		else $error("ineligible source woke idle");

	early_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == shc_pkg::ST_ENTER && wake_req.nmi
		|=> held_nmi && state_reg != shc_pkg::ST_ACT)
		else $error("entry request not held");

	clear_lag_a: assert property (@(posedge mclk) disable iff (!resetn)
		flag_clear_instr |-> ##2 flag_clear_apply)
		else $error("flag clear lag wrong");

	reset_rel_a: assert property (@(posedge mclk)
		!resetn |=> state_reg == shc_pkg::ST_ACT && clk_gate == '1)
		else $error("reset did not release standby");

endmodule
`default_nettype wire

// file: shc_cpu_model.sv
/*
 * Behavioural cpu core and interrupt controller facing the standby
 * halt controller. Assumes one mclk; every request is driven by
 * non-blocking assignment just after a rising edge.
 */
`default_nettype none

module shc_cpu_model (
	input  wire logic             mclk,              // clock
	input  wire logic             serve_pulse,       // wake with service
	input  wire logic             held_nmi,          // nmi held
	input  wire logic             held_ext,          // ext held
	output logic                  halt_exec,         // halt pulse
	output logic [2:0]            irq_mask_level,    // mask level
	output shc_pkg::shc_wake_req_t wake_req,         // requests
	output logic                  held_ack,          // held taken
	output logic                  enable_irq_instr,  // ei pulse
	output logic                  disable_irq_instr, // di pulse
	output logic                  flag_clear_instr   // clear pulse
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		halt_exec = 1'b0;
		irq_mask_level = 3'h0;
		wake_req = '0;
		held_ack = 1'b0;
		enable_irq_instr = 1'b0;
		disable_irq_instr = 1'b0;
		flag_clear_instr = 1'b0;
	end

	// held requests are taken along with the next serviced one
	always @(posedge mclk) begin
		held_ack <= serve_pulse & (held_nmi | held_ext);
	end

	task halt();
		halt_exec <= 1'b1;
		@(posedge mclk);
		halt_exec <= 1'b0;
	endtask

	task set_mask(input logic [2:0] m);
		irq_mask_level <= m;
	endtask

	// src: 0 nmi, 1 ext, 2 wdt, 3 adc, other per
	task req(input int src, input logic [2:0] lvl);
		shc_pkg::shc_wake_req_t w;
		w = '0;
		case (src)
			0: w.nmi = 1'b1;
			1: begin
				w.ext = 1'b1;
				w.ext_lvl = lvl;
			end
			2: {w.wdt, w.wdt_lvl} = {1'b1, lvl};
			3: {w.adc, w.adc_lvl} = {1'b1, lvl};
			default: {w.per, w.per_lvl} = {1'b1, lvl};
		endcase
		wake_req <= w;
		@(posedge mclk);
		// released levels are left at a changed value, not the last one
		w = ~w;
		{w.nmi, w.ext, w.wdt, w.adc, w.per} = 5'h00;
		wake_req <= w;
	endtask

	// two instruction cycles, bits {ei, di, clear}
	task instr(input logic [2:0] a, input logic [2:0] b);
		{enable_irq_instr, disable_irq_instr, flag_clear_instr} <= a;
		@(posedge mclk);
		{enable_irq_instr, disable_irq_instr, flag_clear_instr} <= b;
		@(posedge mclk);
		{enable_irq_instr, disable_irq_instr, flag_clear_instr} <= 3'h0;
	endtask
endmodule
`default_nettype wire

// file: standby_halt_controller_tb_top.sv
/*
 * Self-checking bench of the standby halt controller.
 * Assumes shc_cpu_model as cpu and interrupt controller, one 40 MHz mclk.
 */
`default_nettype none
`include "shc_cfg.svh"
`define SHC_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	errors++; $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end

module standby_halt_controller_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WARM = 3;

	logic                   mclk = 1'b0;
	logic                   resetn = 1'b0;
	logic [4:0]             avs_address = 5'h00;
	logic                   avs_read = 1'b0;
	logic                   avs_write = 1'b0;
	logic [31:0]            avs_writedata = 32'h0000_0000;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   halt_exec;
	logic [2:0]             irq_mask_level;
	shc_pkg::shc_wake_req_t wake_req;
	logic                   held_ack;
	logic                   ei;
	logic                   di;
	logic                   fc;
	shc_pkg::shc_clk_gate_t clk_gate;
	logic                   serve_pulse;
	logic                   resume_pulse;
	logic                   held_nmi;
	logic                   held_ext;
	logic                   ext_flag_keep;
	logic                   irq_enabled;
	logic                   flag_clear_apply;
	logic                   irq;
	int                     errors = 0;
	int                     total_checks = 0;

	always #12.5 mclk = ~mclk;

	shc_standby_ctrl shc_standby_ctrl_i (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.halt_exec(halt_exec), .irq_mask_level(irq_mask_level),
		.wake_req(wake_req), .held_ack(held_ack), .enable_irq_instr(ei),
		.disable_irq_instr(di), .flag_clear_instr(fc),
		.clk_gate(clk_gate), .serve_pulse(serve_pulse),
		.resume_pulse(resume_pulse), .held_nmi(held_nmi),
		.held_ext(held_ext), .ext_flag_keep(ext_flag_keep),
		.irq_enabled(irq_enabled), .flag_clear_apply(flag_clear_apply),
		.irq(irq));

	shc_cpu_model cpu_i (.mclk(mclk), .serve_pulse(serve_pulse),
		.held_nmi(held_nmi), .held_ext(held_ext), .halt_exec(halt_exec),
		.irq_mask_level(irq_mask_level), .wake_req(wake_req),
		.held_ack(held_ack), .enable_irq_instr(ei),
		.disable_irq_instr(di), .flag_clear_instr(fc));

	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task timeout();
		errors++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask

	task bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !w;
		avs_write <= w;
		// waitrequest is combinational on the registered ack, so it is
		// looked at mid-cycle; the next rising edge completes the access
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) timeout();
		@(posedge mclk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		`SHC_CHK(x, e)
	endtask

	function automatic logic [3:0] gate_exp(input logic [1:0] m);
		case (m)
			`SHC_MODE_RUN:   return 4'h7;
			`SHC_MODE_PIDLE: return 4'h3;
			`SHC_MODE_OIDLE: return 4'h1;
			default:         return 4'h0;
		endcase
	endfunction

	task wait_wake(output int n, output logic s);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (serve_pulse !== 1'b1 && resume_pulse !== 1'b1 && n < 12);
		s = serve_pulse;
	endtask

	task try_wake(input logic [1:0] m, input int src, input logic [2:0] lvl,
		input logic woke, input logic srv);
		logic [31:0] d;
		int          n;
		logic        s;
		wr(`SHC_OFS_CTRL, {30'h0000_0000, m});
		cpu_i.halt();
		repeat (6) @(posedge mclk);
		`SHC_CHK(clk_gate, gate_exp(m))
		bus(1'b0, `SHC_OFS_STAT, 32'h0000_0000, d);
		`SHC_CHK(d[5:0], {m, 4'h4})
		cpu_i.req(src, lvl);
		wait_wake(n, s);
		`SHC_CHK(n < 12, woke)
		if (woke) begin
			`SHC_CHK(s, srv)
			if (m == `SHC_MODE_STOP) begin
				`SHC_CHK(n > WARM && n <= WARM + 4, 1'b1)
			end else begin
				`SHC_CHK(n == 1, 1'b1)
			end
		end else begin
			cpu_i.req(0, 3'h7);
			wait_wake(n, s);
			if (n >= 12) timeout();
		end
		`SHC_CHK(clk_gate, 4'hf)
		repeat (2) @(posedge mclk);
	endtask

	task t_reset_values();
		`SHC_CHK(clk_gate, 4'hf)
		rd_chk(`SHC_OFS_CTRL, 32'h0000_0000);
		rd_chk(`SHC_OFS_WARM, 32'h0000_0100);
		rd_chk(`SHC_OFS_MASK, 32'h0000_0000);
		wr(5'h14, 32'hffff_ffff);
		rd_chk(5'h14, 32'h0000_0000);
		rd_chk(`SHC_OFS_CTRL, 32'h0000_0000);
		$display("test reset_values done");
	endtask

	task t_modes();
		wr(`SHC_OFS_WARM, WARM);
		for (int i = 0; i < 4; i++) begin
			try_wake(i[1:0], 0, 3'h7, 1'b1, 1'b1);
		end
		$display("test modes done");
	endtask

	task t_mask();
		cpu_i.set_mask(3'h3);
		try_wake(`SHC_MODE_RUN, 4, 3'h3, 1'b0, 1'b0);
		try_wake(`SHC_MODE_RUN, 4, 3'h4, 1'b1, 1'b1);
		try_wake(`SHC_MODE_RUN, 1, 3'h2, 1'b1, 1'b0);
		`SHC_CHK(ext_flag_keep, 1'b1)
		cpu_i.instr(3'b001, 3'b100);
		@(posedge mclk);
		`SHC_CHK(irq_enabled, 1'b1)
		`SHC_CHK(ext_flag_keep, 1'b1)
		@(posedge mclk);
		`SHC_CHK(ext_flag_keep, 1'b0)
		cpu_i.instr(3'b110, 3'b000);
		@(posedge mclk);
		`SHC_CHK(irq_enabled, 1'b0)
		cpu_i.set_mask(3'h0);
		try_wake(`SHC_MODE_RUN, 2, 3'h7, 1'b1, 1'b1);
		try_wake(`SHC_MODE_PIDLE, 2, 3'h7, 1'b0, 1'b0);
		try_wake(`SHC_MODE_PIDLE, 3, 3'h7, 1'b0, 1'b0);
		try_wake(`SHC_MODE_PIDLE, 4, 3'h7, 1'b1, 1'b1);
		try_wake(`SHC_MODE_OIDLE, 4, 3'h7, 1'b0, 1'b0);
		try_wake(`SHC_MODE_STOP, 1, 3'h7, 1'b1, 1'b1);
		$display("test mask done");
	endtask

	task t_held();
		logic [31:0] d;
		int          n;
		logic        s;
		wr(`SHC_OFS_CTRL, {30'h0000_0000, `SHC_MODE_OIDLE});
		cpu_i.halt();
		cpu_i.req(0, 3'h7);
		repeat (4) @(posedge mclk);
		`SHC_CHK(held_nmi, 1'b1)
		bus(1'b0, `SHC_OFS_STAT, 32'h0000_0000, d);
		`SHC_CHK(d[3:0], 4'h4)
		cpu_i.req(1, 3'h5);
		wait_wake(n, s);
		`SHC_CHK(s, 1'b1)
		repeat (3) @(posedge mclk);
		`SHC_CHK(held_nmi, 1'b0)
		$display("test held done");
	endtask

	task t_irq();
		logic [31:0] d;
		bus(1'b0, `SHC_OFS_EVT, 32'h0000_0000, d);
		wr(`SHC_OFS_MASK, 32'h0000_0001);
		try_wake(`SHC_MODE_RUN, 0, 3'h7, 1'b1, 1'b1);
		`SHC_CHK(irq, 1'b1)
		rd_chk(`SHC_OFS_EVT, 32'h0000_0003);
		`SHC_CHK(irq, 1'b0)
		wr(`SHC_OFS_MASK, 32'h0000_0000);
		try_wake(`SHC_MODE_RUN, 0, 3'h7, 1'b1, 1'b1);
		`SHC_CHK(irq, 1'b0)
		$display("test irq done");
	endtask

	task t_reset_stop();
		logic [31:0] d;
		wr(`SHC_OFS_CTRL, {30'h0000_0000, `SHC_MODE_STOP});
		cpu_i.halt();
		repeat (6) @(posedge mclk);
		`SHC_CHK(clk_gate, 4'h0)
		// hold cut far below 3 ms to keep the run short
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		`SHC_CHK(clk_gate, 4'hf)
		bus(1'b0, `SHC_OFS_STAT, 32'h0000_0000, d);
		`SHC_CHK(d[3:0], 4'h1)
		rd_chk(`SHC_OFS_WARM, 32'h0000_0100);
		rd_chk(`SHC_OFS_CTRL, 32'h0000_0000);
		$display("test reset_stop done");
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset_values();
		t_modes();
		t_mask();
		t_held();
		t_irq();
		t_reset_stop();
		tally_and_finish();
	end
endmodule
`default_nettype wire
